// >>> shared/shift_rotate_pkg.sv
// shared constants, encodings and carriers of the shift and rotate unit
package shift_rotate_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int WORD_W  = 16;
  localparam int PAIR_W  = 2 * WORD_W;
  localparam int MSB_BIT = WORD_W - 1;
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 8;
  localparam int COUNT_W = 16;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_OP_LO_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_OP_HI_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FLAGS_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CTRL_OFS  = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_COUNT_OFS = 8'h10;
  localparam int                CTRL_EN_BIT   = 0;
  localparam logic              CTRL_EN_RST   = 1'h1;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    DOUBLE_SHIFT_LEFT_OP  = 5'h01,
    SHIFT_RIGHT_OP        = 5'h02,
    DOUBLE_SHIFT_RIGHT_OP = 5'h04,
    ROTATE_LEFT_OP        = 5'h08,
    DOUBLE_ROTATE_LEFT_OP = 5'h10
  } op_t;

  typedef enum logic [1:0] {
    MODE_LEVEL = 2'h1,
    MODE_EDGE  = 2'h2
  } mode_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic  cond;
    op_t   op;
    mode_t mode;
    logic  set_carry_op;
    logic  clear_carry_op;
  } issue_t;

  typedef struct packed {
    logic [WORD_W-1:0] hi;
    logic [WORD_W-1:0] lo;
  } word_pair_t;

  typedef struct packed {
    logic fault_indicator;
    logic msb_flag;
    logic equals_flag;
    logic carry_flag;
  } flags_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } apb_rsp_t;

endpackage : shift_rotate_pkg

// >>> logic/shift_core.sv
// combinational shift and rotate datapath with flag results
`timescale 1ns/100ps
module shift_core (
  input  shift_rotate_pkg::op_t        op_in,
  input  shift_rotate_pkg::word_pair_t pair_in,
  input  logic                         carry_in,
  output shift_rotate_pkg::word_pair_t pair_out,
  output shift_rotate_pkg::flags_t     flags_out,
  output logic                         legal_out
);
  import shift_rotate_pkg::*;

  // one-bit move of the selected operation; lo is the addressed word
  always_comb begin
    pair_out  = pair_in;
    flags_out = '0;
    flags_out.carry_flag = carry_in;
    legal_out = 1'h1;
    unique case (op_in)
      DOUBLE_SHIFT_LEFT_OP: begin
        {flags_out.carry_flag, pair_out} = {pair_in, 1'h0};
        flags_out.msb_flag    = pair_out.hi[MSB_BIT];
        flags_out.equals_flag = (pair_out == '0);
      end
      SHIFT_RIGHT_OP: begin
        {pair_out.lo, flags_out.carry_flag} = {1'h0, pair_in.lo};
        flags_out.equals_flag = (pair_out.lo == '0);
      end
      DOUBLE_SHIFT_RIGHT_OP: begin
        {pair_out, flags_out.carry_flag} = {1'h0, pair_in};
        flags_out.equals_flag = (pair_out == '0);
      end
      ROTATE_LEFT_OP: begin
        {flags_out.carry_flag, pair_out.lo} = {pair_in.lo, carry_in};
        flags_out.msb_flag    = pair_out.lo[MSB_BIT];
        flags_out.equals_flag = (pair_out.lo == '0);
      end
      DOUBLE_ROTATE_LEFT_OP: begin
        {flags_out.carry_flag, pair_out} = {pair_in, carry_in};
        flags_out.msb_flag    = pair_out.hi[MSB_BIT];
        flags_out.equals_flag = (pair_out == '0);
      end
      default: begin
        legal_out = 1'h0;
      end
    endcase
  end

endmodule : shift_core

// >>> logic/issue_trigger.sv
// issue mode decoder: every cycle while on, or once on a rising edge
`timescale 1ns/100ps
module issue_trigger (
  input  logic                    clk_in,
  input  logic                    srst_in,
  input  logic                    cond_in,
  input  shift_rotate_pkg::mode_t mode_in,
  output logic                    fire_out
);
  import shift_rotate_pkg::*;

  typedef struct packed {
    logic cond_prev;
  } trig_state_t;

  trig_state_t st_r;
  trig_state_t st_nxt;

  // fire decision and condition history
  always_comb begin
    st_nxt.cond_prev = cond_in;
    unique case (mode_in)
      MODE_LEVEL: fire_out = cond_in;
      MODE_EDGE:  fire_out = cond_in & ~st_r.cond_prev;
      default:    fire_out = 1'h0;
    endcase
  end

  // history reset high: a condition already on at release is no edge
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_r.cond_prev <= 1'h1;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : issue_trigger

// >>> logic/shift_rotate_unit.sv
// shift and rotate unit: operand pair, flags and APB register access
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps

module shift_rotate_unit (
  input  logic                     clk_in,
  input  logic                     srst_in,
  input  shift_rotate_pkg::issue_t issue_in,
  input  shift_rotate_pkg::apb_req_t apb_req_in,
  output shift_rotate_pkg::apb_rsp_t apb_rsp_out,
  output shift_rotate_pkg::word_pair_t pair_out,
  output shift_rotate_pkg::flags_t flags_out,
  output logic                     done_out
);
  import shift_rotate_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // flags and count fields must fit the read data word; slices need two bits
  if ($bits(flags_t) > DATA_W || COUNT_W > DATA_W || WORD_W < 2) begin : g_width_check
    $error("shift unit widths do not fit the register word");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    word_pair_t          pair;
    flags_t              flags;
    logic                enable;
    logic [COUNT_W-1:0]  count;
    logic [DATA_W-1:0]   rdata;
    logic                done;
  } unit_state_t;

  unit_state_t st_r;
  unit_state_t st_nxt;

  word_pair_t  core_pair;
  flags_t      core_flags;
  logic        core_legal;
  logic        fire;
  logic        do_exec;
  logic        carry_eff;
  logic        preset;
  logic        setup;
  logic        access;
  logic        wr;
  logic        hit;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  // issue mode, level or rising edge
  issue_trigger u_trig (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .cond_in  (issue_in.cond),
    .mode_in  (issue_in.mode),
    .fire_out (fire)
  );

  // datapath works on the state pair and the effective carry
  shift_core u_core (
    .op_in     (issue_in.op),
    .pair_in   (st_r.pair),
    .carry_in  (carry_eff),
    .pair_out  (core_pair),
    .flags_out (core_flags),
    .legal_out (core_legal)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // carry preset from the sequencer takes effect in the rotate of the same cycle
  always_comb begin
    preset    = issue_in.set_carry_op | issue_in.clear_carry_op;
    carry_eff = st_r.flags.carry_flag;
    if (issue_in.set_carry_op) begin
      carry_eff = 1'h1;
    end else if (issue_in.clear_carry_op) begin
      carry_eff = 1'h0;
    end
  end

  // execution only when fired, enabled and a legal code
  assign do_exec = fire & st_r.enable & core_legal;

  // apb phases and address hit
  assign setup  = apb_req_in.psel & ~apb_req_in.penable;
  assign access = apb_req_in.psel & apb_req_in.penable;
  assign wr     = access & apb_req_in.pwrite;

  always_comb begin
    case (apb_req_in.paddr)
      REG_OP_LO_OFS,
      REG_OP_HI_OFS,
      REG_FLAGS_OFS,
      REG_CTRL_OFS,
      REG_COUNT_OFS: hit = 1'h1;
      default:       hit = 1'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'h0;
    // read data captured in setup, shown in the access phase
    if (setup) begin
      case (apb_req_in.paddr)
        REG_OP_LO_OFS: st_nxt.rdata = DATA_W'(st_r.pair.lo);
        REG_OP_HI_OFS: st_nxt.rdata = DATA_W'(st_r.pair.hi);
        REG_FLAGS_OFS: st_nxt.rdata = DATA_W'(st_r.flags);
        REG_CTRL_OFS:  st_nxt.rdata = DATA_W'(st_r.enable);
        REG_COUNT_OFS: st_nxt.rdata = DATA_W'(st_r.count);
        default:       st_nxt.rdata = '0;
      endcase
    end
    // software writes, lowest priority
    if (wr) begin
      case (apb_req_in.paddr)
        REG_OP_LO_OFS: st_nxt.pair.lo = apb_req_in.pwdata[WORD_W-1:0];
        REG_OP_HI_OFS: st_nxt.pair.hi = apb_req_in.pwdata[WORD_W-1:0];
        REG_FLAGS_OFS: st_nxt.flags   = flags_t'(apb_req_in.pwdata[$bits(flags_t)-1:0]);
        REG_CTRL_OFS:  st_nxt.enable  = apb_req_in.pwdata[CTRL_EN_BIT];
        default:       st_nxt.rdata   = st_nxt.rdata;
      endcase
    end
    // carry preset overrides a software write of the carry
    if (preset) begin
      st_nxt.flags.carry_flag = carry_eff;
    end
    // execution wins over software; untriggered cycles hold
    if (do_exec) begin
      st_nxt.pair  = core_pair;
      st_nxt.flags = core_flags;
      st_nxt.count = st_r.count + COUNT_W'(1);
      st_nxt.done  = 1'h1;
    end
  end

  // register the state copy
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_r        <= '0;
      st_r.enable <= CTRL_EN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero-wait slave; unmapped or misaligned access answers an error
  assign apb_rsp_out.pready  = 1'h1;
  assign apb_rsp_out.pslverr = access & ~hit;
  assign apb_rsp_out.prdata  = st_r.rdata;
  assign pair_out            = st_r.pair;
  assign flags_out           = st_r.flags;
  assign done_out            = st_r.done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [PAIR_W-1:0] pair_w;
  logic [WORD_W-1:0] hi_w;
  logic [WORD_W-1:0] lo_w;
  logic [PAIR_W-1:0] exp_dsl_w;
  logic [PAIR_W-1:0] exp_dsr_w;
  logic [WORD_W-1:0] exp_shr_w;
  logic [WORD_W-1:0] exp_rol_w;
  logic [PAIR_W-1:0] exp_roll_w;
  logic              hi_msb_w;
  logic              lo_msb_w;
  logic              lo_lsb_w;
  logic              dbl_w;
  logic              cond_w;
  logic              cy_w;
  logic              wr_any_w;
  flags_t            flags_w;
  op_t               op_w;

  // reference values built from the current state
  assign pair_w     = st_r.pair;
  assign hi_w       = st_r.pair.hi;
  assign lo_w       = st_r.pair.lo;
  assign exp_dsl_w  = {pair_w[PAIR_W-2:0], 1'h0};
  assign exp_dsr_w  = {1'h0, pair_w[PAIR_W-1:1]};
  assign exp_shr_w  = {1'h0, lo_w[WORD_W-1:1]};
  assign exp_rol_w  = {lo_w[WORD_W-2:0], carry_eff};
  assign exp_roll_w = {pair_w[PAIR_W-2:0], carry_eff};
  assign hi_msb_w   = hi_w[MSB_BIT];
  assign lo_msb_w   = lo_w[MSB_BIT];
  assign lo_lsb_w   = lo_w[0];
  assign op_w       = issue_in.op;
  assign dbl_w      = (op_w != SHIFT_RIGHT_OP) && (op_w != ROTATE_LEFT_OP);
  assign cond_w     = issue_in.cond;
  assign cy_w       = st_r.flags.carry_flag;
  assign wr_any_w   = wr;
  assign flags_w    = st_r.flags;

  // datapath results, one edge after each execution
  a_dsl_shift: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec && op_w == DOUBLE_SHIFT_LEFT_OP
    |=> pair_w == $past(exp_dsl_w) && cy_w == $past(hi_msb_w))
    else $error("double shift left result wrong");

  a_shr_shift: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec && op_w == SHIFT_RIGHT_OP
    |=> lo_w == $past(exp_shr_w) && hi_w == $past(hi_w) && cy_w == $past(lo_lsb_w))
    else $error("shift right result wrong");

  a_dsr_shift: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec && op_w == DOUBLE_SHIFT_RIGHT_OP
    |=> pair_w == $past(exp_dsr_w) && cy_w == $past(lo_lsb_w))
    else $error("double shift right result wrong");

  a_rol_ring: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec && op_w == ROTATE_LEFT_OP
    |=> lo_w == $past(exp_rol_w) && hi_w == $past(hi_w) && cy_w == $past(lo_msb_w))
    else $error("rotate left ring wrong");

  a_roll_ring: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec && op_w == DOUBLE_ROTATE_LEFT_OP
    |=> pair_w == $past(exp_roll_w) && cy_w == $past(hi_msb_w))
    else $error("double rotate left ring wrong");

  a_fault_clear: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec |-> ##1 !flags_w.fault_indicator)
    else $error("fault indicator not cleared");

  a_equals_flag: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec |=> flags_w.equals_flag == ($past(dbl_w) ? (pair_w == '0) : (lo_w == '0)))
    else $error("equals flag wrong");

  a_msb_flag: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec && (op_w == DOUBLE_SHIFT_LEFT_OP || op_w == ROTATE_LEFT_OP)
    |=> flags_w.msb_flag == ($past(dbl_w) ? hi_msb_w : lo_msb_w))
    else $error("msb flag wrong");

  a_shr_msb_off: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec && (op_w == SHIFT_RIGHT_OP || op_w == DOUBLE_SHIFT_RIGHT_OP)
    |=> !flags_w.msb_flag && !flags_w.fault_indicator)
    else $error("right shift left msb or fault on");

  a_edge_once: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec && issue_in.mode == MODE_EDGE |-> $rose(cond_w))
    else $error("edge mode fired without rising edge");

  a_idle_hold: assert property (@(posedge clk_in) disable iff (srst_in)
    !do_exec && !wr_any_w && !preset |=> $stable(pair_w) && $stable(flags_w))
    else $error("state changed without execution");

  // issue modes: level fires on every high cycle, edge never twice running
  a_level_fire: assert property (@(posedge clk_in) disable iff (srst_in)
    cond_w && issue_in.mode == MODE_LEVEL && st_r.enable && $onehot(op_w) |-> do_exec)
    else $error("level mode did not execute");

  a_edge_single: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec && issue_in.mode == MODE_EDGE |=> !(do_exec && issue_in.mode == MODE_EDGE))
    else $error("edge mode executed twice in a row");

  a_cond_low: assert property (@(posedge clk_in) disable iff (srst_in)
    !cond_w |-> !do_exec)
    else $error("execution without the condition");

  a_mode_refuse: assert property (@(posedge clk_in) disable iff (srst_in)
    !(issue_in.mode inside {MODE_LEVEL, MODE_EDGE}) |-> !do_exec)
    else $error("execution under an unknown issue mode");

  a_legal_op: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec |-> $onehot(op_w))
    else $error("execution of an unknown op code");

  a_done_pulse: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec |=> done_out)
    else $error("done pulse missing after execution");

  // carry presets: taken alone, or consumed by the rotate of that cycle
  a_preset_set: assert property (@(posedge clk_in) disable iff (srst_in)
    issue_in.set_carry_op && !do_exec |=> cy_w)
    else $error("carry preset to one not taken");

  a_preset_clear: assert property (@(posedge clk_in) disable iff (srst_in)
    issue_in.clear_carry_op && !issue_in.set_carry_op && !do_exec |=> !cy_w)
    else $error("carry preset to zero not taken");

  a_preset_used: assert property (@(posedge clk_in) disable iff (srst_in)
    preset && do_exec && (op_w == ROTATE_LEFT_OP || op_w == DOUBLE_ROTATE_LEFT_OP)
    |=> lo_w[0] == $past(issue_in.set_carry_op))
    else $error("rotate did not consume the preset carry");

  // double rotate msb, fault history and a disabled unit
  a_roll_msb: assert property (@(posedge clk_in) disable iff (srst_in)
    do_exec && op_w == DOUBLE_ROTATE_LEFT_OP |=> flags_w.msb_flag == hi_msb_w)
    else $error("double rotate msb flag wrong");

  a_fault_hold: assert property (@(posedge clk_in) disable iff (srst_in)
    !do_exec && !wr_any_w |=> $stable(flags_w.fault_indicator))
    else $error("fault indicator changed without a cause");

  a_disabled_hold: assert property (@(posedge clk_in) disable iff (srst_in)
    !st_r.enable && !wr_any_w && !preset |=> $stable(pair_w) && $stable(flags_w))
    else $error("disabled unit changed its state");

  c_disabled_try: cover property (@(posedge clk_in) disable iff (srst_in)
    cond_w && !st_r.enable);

  c_dsl_exec: cover property (@(posedge clk_in) disable iff (srst_in)
    do_exec && op_w == DOUBLE_SHIFT_LEFT_OP);

  c_edge_fire: cover property (@(posedge clk_in) disable iff (srst_in)
    do_exec && issue_in.mode == MODE_EDGE);

  c_preset_roll: cover property (@(posedge clk_in) disable iff (srst_in)
    preset ##1 do_exec && op_w == DOUBLE_ROTATE_LEFT_OP);

  c_level_run: cover property (@(posedge clk_in) disable iff (srst_in)
    do_exec && issue_in.mode == MODE_LEVEL ##1 do_exec);

endmodule : shift_rotate_unit

// >>> dv/seq_model.sv
// instruction sequencer model: drives condition, op code, issue mode and carry presets
`timescale 1ns/100ps
module seq_model (
  input  logic                     clk_in,
  output shift_rotate_pkg::issue_t issue_out
);
  import shift_rotate_pkg::*;

  // ----------------------------------------------------------------
  // idle until asked to issue
  // ----------------------------------------------------------------
  initial issue_out = '0;

  // ----------------------------------------------------------------
  // one issue: condition high for ncyc edges, or a lone preset cycle
  // ----------------------------------------------------------------
  // the bench requests the level and rising-edge modes, and once the unknown mode 2'h3
  // a preset rides along with, or just ahead of, the rotate that uses it
  // double ops always see a full held pair, so a second word exists
  task automatic issue(input op_t op, input mode_t md, input int ncyc,
                       input logic set_c, input logic clr_c);
    @(posedge clk_in);
    issue_out <= '{cond: (ncyc > 0), op: op, mode: md,
                   set_carry_op: set_c, clear_carry_op: clr_c};
    repeat ((ncyc > 0) ? ncyc : 1) @(posedge clk_in);
    issue_out <= '0;
  endtask : issue
endmodule : seq_model

// >>> dv/shift_rotate_unit_test.sv
// self-checking bench for the shift and rotate unit
`timescale 1ns/100ps
module shift_rotate_unit_test;
  import shift_rotate_pkg::*;

  // ----------------------------------------------------------------
  // signals and counters
  // ----------------------------------------------------------------
  logic       clk_in = 1'h0;
  logic       srst_in = 1'h1;
  issue_t     issue;
  apb_req_t   req = '0;
  apb_rsp_t   rsp;
  word_pair_t pair;
  flags_t     flags;
  logic       done;
  int         mismatches = 0;
  int         tests_run = 0;
  int         done_cnt = 0;
  int         cyc = 0;

  shift_rotate_unit uut (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .issue_in    (issue),
    .apb_req_in  (req),
    .apb_rsp_out (rsp),
    .pair_out    (pair),
    .flags_out   (flags),
    .done_out    (done)
  );

  seq_model seq (
    .clk_in    (clk_in),
    .issue_out (issue)
  );

  // 20 MHz clock
  always #25 clk_in = ~clk_in;

  // done pulse count and hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (done === 1'h1) done_cnt <= done_cnt + 1;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer: setup, then access until pready at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_in);
    req.penable <= 1'h1;
    // the first access edge sees pready high and ends this wait
    do begin
      @(posedge clk_in);
    end while (rsp.pready !== 1'h1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'h1, a, d, rd, err);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'h0, a, 32'h0, rd, err);
    chk(what, exp, rd);
  endtask : rdchk

  // expected {pair, fault, msb, equals, carry} of one execution
  function automatic logic [35:0] expect_op(input op_t op, input logic [31:0] v,
                                            input logic c);
    logic [31:0] r;
    logic        co;
    logic        m;
    logic        z;
    case (op)
      DOUBLE_SHIFT_LEFT_OP:  {co, r} = {v, 1'h0};
      SHIFT_RIGHT_OP:        {r, co} = {v[31:16], 1'h0, v[15:0]};
      DOUBLE_SHIFT_RIGHT_OP: {r, co} = {1'h0, v};
      ROTATE_LEFT_OP:        {r[31:16], co, r[15:0]} = {v, c};
      default:               {co, r} = {v, c};
    endcase
    z = (op == SHIFT_RIGHT_OP || op == ROTATE_LEFT_OP) ? (r[15:0] == 16'h0) : (r == 32'h0);
    m = (op == ROTATE_LEFT_OP) ? r[15] : (op == SHIFT_RIGHT_OP || op == DOUBLE_SHIFT_RIGHT_OP)
        ? 1'h0 : r[31];
    return {r, 1'h0, m, z, co};
  endfunction : expect_op

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("pair", 32'h0, pair);
    chk("flags", 32'h0, {28'h0, flags});
    rdchk("ctrl", REG_CTRL_OFS, 32'h1);
    rdchk("count", REG_COUNT_OFS, 32'h0);
  endtask : t_reset

  // every op on boundary pairs, both carries, stale flags preset high
  task automatic t_ops();
    logic [31:0] vec [4] = '{32'h8001_8001, 32'h0000_8000, 32'h8000_0000, 32'h0000_0001};
    op_t         ops [5] = '{DOUBLE_SHIFT_LEFT_OP, SHIFT_RIGHT_OP, DOUBLE_SHIFT_RIGHT_OP,
                             ROTATE_LEFT_OP, DOUBLE_ROTATE_LEFT_OP};
    logic [35:0] e;
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 8; j++) begin
        wr(REG_OP_LO_OFS, {16'h0, vec[j/2][15:0]});
        wr(REG_OP_HI_OFS, {16'h0, vec[j/2][31:16]});
        wr(REG_FLAGS_OFS, {28'h0, 3'h7, j[0]});
        e = expect_op(ops[i], vec[j/2], j[0]);
        seq.issue(ops[i], MODE_LEVEL, 1, 1'h0, 1'h0);
        #1;
        chk("pair", e[35:4], pair);
        chk("flags", {28'h0, e[3:0]}, {28'h0, flags});
      end
    end
    rdchk("count", REG_COUNT_OFS, 32'h28);
  endtask : t_ops

  // edge mode fires once, level mode every cycle, refused issues do nothing
  task automatic t_modes();
    int c0;
    wr(REG_OP_LO_OFS, 32'h1);
    wr(REG_FLAGS_OFS, 32'h0);
    c0 = done_cnt;
    seq.issue(ROTATE_LEFT_OP, MODE_EDGE, 4, 1'h0, 1'h0);
    repeat (2) @(posedge clk_in);
    #1;
    chk("edge pair", 32'h2, pair);
    chk("edge done", c0 + 1, done_cnt);
    seq.issue(ROTATE_LEFT_OP, MODE_LEVEL, 3, 1'h0, 1'h0);
    repeat (2) @(posedge clk_in);
    #1;
    chk("level pair", 32'h10, pair);
    chk("level done", c0 + 4, done_cnt);
    seq.issue(op_t'(5'h03), MODE_LEVEL, 2, 1'h0, 1'h0);
    seq.issue(ROTATE_LEFT_OP, mode_t'(2'h3), 2, 1'h0, 1'h0);
    seq.issue(ROTATE_LEFT_OP, MODE_LEVEL, 0, 1'h0, 1'h0);
    wr(REG_CTRL_OFS, 32'h0);
    seq.issue(ROTATE_LEFT_OP, MODE_LEVEL, 2, 1'h0, 1'h0);
    wr(REG_CTRL_OFS, 32'h1);
    #1;
    chk("idle pair", 32'h10, pair);
    chk("idle flags", 32'h0, {28'h0, flags});
    chk("idle done", c0 + 4, done_cnt);
  endtask : t_modes

  // carry preset in the rotate cycle and just ahead of it
  task automatic t_preset();
    wr(REG_OP_LO_OFS, 32'h1);
    wr(REG_FLAGS_OFS, 32'h0);
    seq.issue(ROTATE_LEFT_OP, MODE_LEVEL, 1, 1'h1, 1'h0);
    #1;
    chk("set pair", 32'h3, pair);
    wr(REG_FLAGS_OFS, 32'h1);
    seq.issue(ROTATE_LEFT_OP, MODE_LEVEL, 0, 1'h0, 1'h1);
    seq.issue(ROTATE_LEFT_OP, MODE_LEVEL, 1, 1'h0, 1'h0);
    #1;
    chk("clear pair", 32'h6, pair);
    chk("clear flags", 32'h0, {28'h0, flags});
    seq.issue(DOUBLE_ROTATE_LEFT_OP, MODE_LEVEL, 2, 1'h1, 1'h0);
    #1;
    chk("set roll pair", 32'h1B, pair);
    chk("set roll flags", 32'h0, {28'h0, flags});
  endtask : t_preset

  // unmapped and misaligned accesses are refused
  task automatic t_apb();
    logic [31:0] d;
    logic        e;
    apb(1'h0, 8'h14, 32'h0, d, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, d);
    apb(1'h1, 8'h02, 32'hFFFF, d, e);
    chk("misaligned err", 32'h1, {31'h0, e});
    rdchk("lo kept", REG_OP_LO_OFS, 32'h1B);
  endtask : t_apb

  // ----------------------------------------------------------------
  // closing report
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_in);
    srst_in <= 1'h0;
    #1;
    t_reset();
    t_ops();
    t_modes();
    t_preset();
    t_apb();
    report_and_stop();
  end
endmodule : shift_rotate_unit_test
